/* hdu_pkg.sv */
package hdu_pkg;
    // register offsets on the plain port
    localparam logic [1:0] HDU_ADDR_DATA = 2'h0;
    localparam logic [1:0] HDU_ADDR_CTRL = 2'h1;
    // control register field positions
    localparam int HDU_BIT_NINTH = 0;
    localparam int HDU_BIT_BAUD_LO = 1;
    localparam int HDU_BIT_TX_IEN = 4;
    localparam int HDU_BIT_RX_IEN = 5;
    localparam int HDU_BIT_TX_EMPTY = 6;
    localparam int HDU_BIT_RX_READY = 7;
    // reset values
    localparam logic [7:0] HDU_CTRL_RESET = 8'h00;
    localparam logic [7:0] HDU_DATA_RESET = 8'h00;
    // states per bit and sample points
    localparam logic [2:0] HDU_STATES_LAST = 3'h7;
    localparam logic [2:0] HDU_SAMPLE_A = 3'h4;
    localparam logic [2:0] HDU_SAMPLE_B = 3'h5;
    localparam logic [2:0] HDU_SAMPLE_C = 3'h6;
    // bits after the start bit: nine data plus stop for transmit, nine data for receive
    localparam logic [3:0] HDU_TX_LAST_BIT = 4'ha;
    localparam logic [3:0] HDU_RX_LAST_BIT = 4'h9;
    // divisor per eight-state tick = fint division / 8
    localparam logic [9:0] HDU_DIV_0 = 10'h340; // 6656/8
    localparam logic [9:0] HDU_DIV_1 = 10'h1a0; // 3328/8
    localparam logic [9:0] HDU_DIV_2 = 10'h0d0; // 1664/8
    localparam logic [9:0] HDU_DIV_3 = 10'h068; // 832/8
    localparam logic [9:0] HDU_DIV_4 = 10'h034; // 416/8
    localparam logic [9:0] HDU_DIV_5 = 10'h020; // 256/8
    localparam logic [9:0] HDU_DIV_6 = 10'h01a; // 208/8
    localparam logic [9:0] HDU_DIV_RSVD = 10'h01a; // reserved code
    typedef enum logic [1:0] {HDU_IDLE, HDU_TX, HDU_RX} hdu_mode_e;
endpackage

/* hdu_remote.sv */
`timescale 1ns/10ps
module hdu_remote #(parameter int BIT_CLKS = 208) (
    // clock
    input wire logic clk_sys,
    // line from the block and its frame window
    input wire logic tx_pin,
    input wire logic frame,
    // line into the block and the caught frame
    output logic rx_line,
    output logic [10:0] caught
);
    // remote idles in the stop state
    initial rx_line = 1'b1;
    // mid-bit capture, undoing the pin inversion
    always @(posedge frame) begin
        repeat (BIT_CLKS / 2) @(posedge clk_sys);
        for (int k = 0; k < 11; k++) begin
            caught[k] = ~tx_pin;
            if (k < 10) repeat (BIT_CLKS) @(posedge clk_sys);
        end
    end
    // one character lsb first, with an optional one-sample glitch per data bit
    task automatic send(input logic [8:0] d, input bit glitch);
        logic [10:0] f;
        f = {1'b1, d, 1'b0};
        for (int k = 0; k < 11; k++) begin
            rx_line <= f[k];
            repeat (BIT_CLKS / 2 + 16) @(posedge clk_sys);
            if (glitch && k > 0 && k < 10) rx_line <= ~f[k];
            repeat (20) @(posedge clk_sys);
            rx_line <= f[k];
            repeat (BIT_CLKS / 2 - 36) @(posedge clk_sys);
        end
    endtask
endmodule

/* hdu_uart.sv */
`timescale 1ns/10ps
// Functional notes
// - half duplex only, 11-bit characters: start, nine data, stop.
// - received character buffered so the next one can assemble meanwhile.
// - transmit activity has priority over receive.
// - serial output pin carries the transmit stream inverted.
// - when not sending, output pin reflects the port register value.
// - divider makes a tick at eight times the selected baud rate.
// - each received bit decided by two-of-three majority of samples.
// - start and stop generated, parity left to software.
// - ninth transmit bit kept until software or reception changes it.
// - data write selects serial path, sends start, eight bits lsb first, ninth.
// - one high stop bit, then serial output select drops.
// - finished transmission sets transmit empty flag, interrupt if enabled.
// - transmit empty cleared by writing zero or by data write.
// - writing one to transmit empty sets it, software interrupt.
// - receiver watches for falling edge only while idle, neither transmitting nor receiving.
// - after edge, wait one bit time, then shift in nine bits.
// - received ninth bit replaces stored ninth bit.
// - after stop time, character to buffer, ready flag set, interrupt.
// - transmit start aborts an ongoing reception.
// - three-bit baud field selects divisor, reserved code, immediate effect.
// - data address reads receive buffer, writes transmit shift register.
// - ready flag cleared by writing zero, enables only gate requests.
module hdu_uart
    import hdu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // serial pins and port function
    input wire logic serial_input_pin,
    input wire logic port_out_value,
    output logic serial_output_pin,
    output logic serial_output_select,
    // interrupt requests to the core
    output logic transmit_irq,
    output logic receive_irq
);

    typedef struct packed {
        logic [1:0] rx_sync;
        logic rx_prev;
        logic [9:0] div_cnt;
        logic tick;
        hdu_mode_e mode;
        logic [2:0] state_cnt;
        logic [3:0] bit_cnt;
        logic [1:0] votes;
        logic [7:0] tx_shift;
        logic [8:0] rx_shift;
        logic [7:0] rx_buffer;
        logic ninth_bit;
        logic [2:0] baud_select_field;
        logic transmit_irq_enable;
        logic receive_irq_enable;
        logic transmit_empty_flag;
        logic receive_ready_flag;
        logic [7:0] rdata;
        logic pin;
        logic sel;
        logic tx_irq;
        logic rx_irq;
    } hdu_state_s;

    hdu_state_s s_q;
    hdu_state_s s_d;
    logic [9:0] div_top;
    logic rx_bit;
    logic tx_level;
    logic data_wr;
    logic ctrl_wr;
    logic tx_done;
    logic rx_done;

    // divisor lookup, field change acts at once
    always_comb begin
        case (s_q.baud_select_field)
            3'h0: div_top = HDU_DIV_0;
            3'h1: div_top = HDU_DIV_1;
            3'h2: div_top = HDU_DIV_2;
            3'h3: div_top = HDU_DIV_3;
            3'h4: div_top = HDU_DIV_4;
            3'h5: div_top = HDU_DIV_5;
            3'h6: div_top = HDU_DIV_6;
            default: div_top = HDU_DIV_RSVD;
        endcase
    end

    // bus decode and serial helpers
    assign data_wr = reg_wr && (reg_addr == HDU_ADDR_DATA);
    assign ctrl_wr = reg_wr && (reg_addr == HDU_ADDR_CTRL);
    assign rx_bit = s_q.rx_sync[1];

    // next-state logic
    always_comb begin
        s_d = s_q;
        tx_done = 1'b0;
        rx_done = 1'b0;
        tx_level = 1'b1;
        s_d.rx_sync = {s_q.rx_sync[0], serial_input_pin};
        s_d.rx_prev = rx_bit;

        // eight-state tick divider
        s_d.tick = 1'b0;
        if (s_q.div_cnt >= div_top - 10'h001) begin
            s_d.div_cnt = 10'h000;
            s_d.tick = 1'b1;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 10'h001;
        end

        // current transmit level: start, data lsb first, ninth, stop
        if (s_q.bit_cnt == 4'h0) begin
            tx_level = 1'b0;
        end else if (s_q.bit_cnt <= 4'h8) begin
            tx_level = s_q.tx_shift[0];
        end else if (s_q.bit_cnt == 4'h9) begin
            tx_level = s_q.ninth_bit;
        end else begin
            tx_level = 1'b1;
        end

        case (s_q.mode)
            HDU_IDLE: begin
                // start edge seen while not sending
                if (s_q.rx_prev && !rx_bit) begin
                    s_d.mode = HDU_RX;
                    s_d.state_cnt = 3'h0;
                    s_d.bit_cnt = 4'h0;
                    s_d.div_cnt = 10'h000;
                    s_d.tick = 1'b0; // stale tick would shorten the start bit
                end
            end
            HDU_TX: begin
                if (s_q.tick) begin
                    s_d.state_cnt = s_q.state_cnt + 3'h1;
                    if (s_q.state_cnt == HDU_STATES_LAST) begin
                        if (s_q.bit_cnt >= 4'h1 && s_q.bit_cnt <= 4'h8) begin
                            s_d.tx_shift = {1'b0, s_q.tx_shift[7:1]};
                        end
                        if (s_q.bit_cnt == HDU_TX_LAST_BIT) begin
                            s_d.mode = HDU_IDLE;
                            tx_done = 1'b1;
                        end else begin
                            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        end
                    end
                end
            end
            HDU_RX: begin
                if (s_q.tick) begin
                    s_d.state_cnt = s_q.state_cnt + 3'h1;
                    // three samples in mid states
                    if (s_q.state_cnt == HDU_SAMPLE_A) begin
                        s_d.votes = {1'b0, rx_bit};
                    end else if (s_q.state_cnt == HDU_SAMPLE_B
                                 || s_q.state_cnt == HDU_SAMPLE_C) begin
                        s_d.votes = s_q.votes + {1'b0, rx_bit};
                    end
                    if (s_q.state_cnt == HDU_STATES_LAST) begin
                        // bit 0 is the start bit, passed over
                        if (s_q.bit_cnt >= 4'h1 && s_q.bit_cnt <= HDU_RX_LAST_BIT) begin
                            s_d.rx_shift = {(s_q.votes >= 2'h2), s_q.rx_shift[8:1]};
                        end
                        if (s_q.bit_cnt == HDU_TX_LAST_BIT) begin
                            s_d.mode = HDU_IDLE;
                            rx_done = 1'b1;
                        end else begin
                            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        end
                    end
                end
            end
            default: s_d.mode = HDU_IDLE;
        endcase

        // character complete: buffer and ninth bit
        if (rx_done) begin
            s_d.rx_buffer = s_q.rx_shift[7:0];
            s_d.ninth_bit = s_q.rx_shift[8];
        end

        // control register write
        if (ctrl_wr) begin
            s_d.ninth_bit = reg_wdata[HDU_BIT_NINTH];
            s_d.baud_select_field = reg_wdata[HDU_BIT_BAUD_LO +: 3];
            s_d.transmit_irq_enable = reg_wdata[HDU_BIT_TX_IEN];
            s_d.receive_irq_enable = reg_wdata[HDU_BIT_RX_IEN];
            s_d.transmit_empty_flag = reg_wdata[HDU_BIT_TX_EMPTY];
            s_d.receive_ready_flag = reg_wdata[HDU_BIT_RX_READY];
        end

        // data write launches a character, aborting any reception
        if (data_wr) begin
            s_d.mode = HDU_TX;
            s_d.tx_shift = reg_wdata;
            s_d.bit_cnt = 4'h0;
            s_d.state_cnt = 3'h0;
            s_d.div_cnt = 10'h000;
            s_d.tick = 1'b0; // full first state after launch
            s_d.transmit_empty_flag = 1'b0;
        end

        // hardware sets win over software clears
        if (tx_done) begin
            s_d.transmit_empty_flag = 1'b1;
        end
        if (rx_done) begin
            s_d.receive_ready_flag = 1'b1;
        end

        // read data, one cycle later
        s_d.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == HDU_ADDR_DATA) begin
                s_d.rdata = s_q.rx_buffer;
            end else if (reg_addr == HDU_ADDR_CTRL) begin
                s_d.rdata = {s_q.receive_ready_flag, s_q.transmit_empty_flag,
                             s_q.receive_irq_enable, s_q.transmit_irq_enable,
                             s_q.baud_select_field, s_q.ninth_bit};
            end
        end

        // pin multiplexer, inverted serial stream
        s_d.sel = (s_d.mode == HDU_TX);
        if (s_q.mode == HDU_TX) begin
            s_d.pin = ~tx_level;
        end else begin
            s_d.pin = port_out_value;
        end
        if (s_d.mode != HDU_TX) begin
            s_d.sel = 1'b0;
        end

        // requests gated by enables, flags untouched
        s_d.tx_irq = s_d.transmit_empty_flag && s_d.transmit_irq_enable;
        s_d.rx_irq = s_d.receive_ready_flag && s_d.receive_irq_enable;
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
            s_q.rx_sync <= 2'h3;
            s_q.rx_prev <= 1'b1;
            s_q.mode <= HDU_IDLE;
            s_q.pin <= 1'b1;
            s_q.rdata <= HDU_DATA_RESET;
            {s_q.receive_ready_flag, s_q.transmit_empty_flag, s_q.receive_irq_enable,
             s_q.transmit_irq_enable, s_q.baud_select_field, s_q.ninth_bit}
                <= HDU_CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = s_q.rdata;
    assign serial_output_pin = s_q.pin;
    assign serial_output_select = s_q.sel;
    assign transmit_irq = s_q.tx_irq;
    assign receive_irq = s_q.rx_irq;

endmodule

/* hdu_uart_assertions.sv */
`timescale 1ns/10ps
module hdu_uart_checker
    import hdu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins and requests
    input wire logic port_out_value,
    input wire logic serial_output_pin,
    input wire logic serial_output_select,
    input wire logic transmit_irq,
    input wire logic receive_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // register writes by target
    sequence s_data_wr;
        reg_wr && reg_addr == HDU_ADDR_DATA;
    endsequence
    sequence s_ctrl_wr;
        reg_wr && reg_addr == HDU_ADDR_CTRL;
    endsequence
    property p_select_on_write;
        s_data_wr |=> serial_output_select;
    endproperty
    a_select_on_write: assert property (p_select_on_write) else $error("no select");
    property p_start_level;
        $rose(serial_output_select) |-> serial_output_pin [*8];
    endproperty
    a_start_level: assert property (p_start_level) else $error("bad start");
    property p_stop_level;
        $fell(serial_output_select) |-> !$past(serial_output_pin);
    endproperty
    a_stop_level: assert property (p_stop_level) else $error("bad stop");
    property p_port_follow;
        !serial_output_select && !$past(serial_output_select) && !$past(rst)
            |-> serial_output_pin == $past(port_out_value);
    endproperty
    a_port_follow: assert property (p_port_follow) else $error("pin not port");
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
    property p_unmapped;
        reg_rd && reg_addr[1] |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_sw_tx_irq;
        s_ctrl_wr ##0 (reg_wdata[HDU_BIT_TX_EMPTY] && reg_wdata[HDU_BIT_TX_IEN]) |-> ##2 transmit_irq;
    endproperty
    a_sw_tx_irq: assert property (p_sw_tx_irq) else $error("no sw irq");
    property p_tx_gate;
        s_ctrl_wr ##0 !reg_wdata[HDU_BIT_TX_IEN] |-> ##2 !transmit_irq;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx irq ungated");
    property p_rx_gate;
        s_ctrl_wr ##0 !reg_wdata[HDU_BIT_RX_IEN] |-> ##2 !receive_irq;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx irq ungated");
    property p_wr_clears;
        s_data_wr |-> ##2 !transmit_irq;
    endproperty
    a_wr_clears: assert property (p_wr_clears) else $error("empty not cleared");
endmodule
bind hdu_uart hdu_uart_checker chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_out_value(port_out_value), .serial_output_pin(serial_output_pin),
    .serial_output_select(serial_output_select), .transmit_irq(transmit_irq),
    .receive_irq(receive_irq));

/* hdu_uart_test.sv */
`timescale 1ns/10ps
module hdu_uart_test
    import hdu_pkg::*;
;
    logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, port_out_value = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v, prev;
    logic serial_input_pin, serial_output_pin, serial_output_select, transmit_irq, receive_irq;
    logic [10:0] caught;
    logic [31:0] rng = 32'h5f;
    int fail_count = 0, comparisons = 0, n;
    int divs[8] = '{6656, 3328, 1664, 832, 416, 256, 208, 208};
    always #20 clk_sys = ~clk_sys;
    hdu_uart dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_input_pin(serial_input_pin), .port_out_value(port_out_value),
        .serial_output_pin(serial_output_pin), .serial_output_select(serial_output_select),
        .transmit_irq(transmit_irq), .receive_irq(receive_irq));
    hdu_remote far (.clk_sys(clk_sys), .tx_pin(serial_output_pin),
        .frame(serial_output_select), .rx_line(serial_input_pin), .caught(caught));
    // xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task complete_run;
        if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [10:0] got, input logic [10:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [1:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    // cycles until the named output drops, bounded
    task wait_low(input bit pin_sel);
        n = 0;
        @(posedge clk_sys);
        while ((pin_sel ? serial_output_pin : serial_output_select) === 1'b1 && n < 9000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    // watchdog
    initial begin
        repeat (60000) @(posedge clk_sys);
        fail_count++;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(HDU_ADDR_CTRL);
        chk(rd_v, HDU_CTRL_RESET);
        rd(HDU_ADDR_DATA);
        chk(rd_v, HDU_DATA_RESET);
        wr(2'h3, 8'hff);
        rd(2'h2);
        chk(rd_v, 8'h00);
        // idle pin follows a wandering port value, then stop level held
        repeat (8) begin
            rng = xs(rng);
            @(posedge clk_sys) port_out_value <= rng[0];
        end
        @(posedge clk_sys) port_out_value <= 1'b1;
        wr(HDU_ADDR_CTRL, 8'h5c);
        rd(HDU_ADDR_CTRL);
        chk({rd_v, 2'b00, transmit_irq}, {8'h5c, 3'h1});
        wr(HDU_ADDR_CTRL, 8'h3d);
        rd(HDU_ADDR_CTRL);
        chk({rd_v, 2'b00, transmit_irq}, {8'h3d, 3'h0});
        // back-to-back random characters, ninth bit kept
        repeat (3) begin
            rng = xs(rng);
            wr(HDU_ADDR_DATA, rng[7:0]);
            wait_low(1'b0);
            chk(caught, {2'b11, rng[7:0], 1'b0});
            chk(11'((n + 13) / 26), 11'd88);
            repeat (2) @(posedge clk_sys);
            #1 chk({10'h0, transmit_irq}, 11'h1);
        end
        // reception with glitches; buffer read while the next one assembles
        prev = HDU_DATA_RESET;
        for (int i = 0; i < 2; i++) begin
            rng = xs(rng);
            fork
                far.send({i[0], rng[7:0]}, 1'b1);
                begin
                    repeat (900) @(posedge clk_sys);
                    rd(HDU_ADDR_DATA);
                    chk(rd_v, prev);
                end
            join
            n = 0;
            while (receive_irq !== 1'b1 && n < 600) @(posedge clk_sys) n++;
            rd(HDU_ADDR_DATA);
            chk(rd_v, rng[7:0]);
            prev = rng[7:0];
            rd(HDU_ADDR_CTRL);
            chk(rd_v, {7'h7e, i[0]});
            wr(HDU_ADDR_CTRL, {7'h1e, i[0]});
            rd(HDU_ADDR_CTRL);
            chk({rd_v, 2'b00, receive_irq}, {7'h1e, i[0], 3'h0});
            wr(HDU_ADDR_CTRL, {7'h3e, i[0]});
        end
        // transmit launched mid-reception aborts it
        fork
            far.send(9'h0a5, 1'b0);
            begin
                repeat (700) @(posedge clk_sys);
                wr(HDU_ADDR_DATA, 8'h3c);
            end
        join
        wait_low(1'b0);
        repeat (300) @(posedge clk_sys);
        chk(caught, {2'b11, 8'h3c, 1'b0});
        rd(HDU_ADDR_CTRL);
        chk({10'h0, rd_v[HDU_BIT_RX_READY] | receive_irq}, 11'h0);
        // start bit length per baud code, each cut short by reset
        for (int c = 0; c < 8; c++) begin
            wr(HDU_ADDR_CTRL, {4'h0, 3'(c), 1'b0});
            wr(HDU_ADDR_DATA, 8'h01);
            wait_low(1'b1);
            chk(11'((n + divs[c] / 16) / (divs[c] / 8)), 11'd8);
            rst <= 1'b1;
            repeat (5) @(posedge clk_sys);
            rst <= 1'b0;
        end
        complete_run;
    end
endmodule
